// ===== bench/scd_cmd_decoder_assertions.sv
// Purpose: Temporal checks on the command decoder's user outputs.
// Assumes: One clock domain, reset active high.
// Notes:   Bound to every decoder instance by the line after the module.
`timescale 1ns/10ps
`default_nettype none
`include "scd_defines.vh"
// ==========================================================================
// Checker
// ==========================================================================
module scd_cmd_chk #(
   parameter INIT_CYCLES = 8
) (
   input wire logic        CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        CMD_EXEC_O,
   input wire logic [5:0]  CMD_INDEX_O,
   input wire logic [31:0] CMD_ARG_O,
   input wire logic [31:0] BLOCK_LEN_O,
   input wire logic [15:0] BLOCK_COUNT_O,
   input wire logic        COUNTED_O,
   input wire logic        IN_IDLE_O,
   input wire logic        RESP_STB_O,
   input wire logic [7:0]  RESP_O
);
   // Indices allowed to run, the operating-conditions read included.
   localparam logic [63:0] RUN_SET = `SCD_SUPPORTED_MASK;
   // Cycles from the sampled start pulse to the sampled fall of the idle flag.
   localparam int INIT_LAG = INIT_CYCLES + 1;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // Outputs may lag the strobe by one register, hence the short ranges.
   a_exec_has_resp: assert property (CMD_EXEC_O |-> RESP_STB_O)
      else $error("exec without response");
   a_exec_no_error: assert property (CMD_EXEC_O |-> !(RESP_O[6] | RESP_O[3] | RESP_O[2]))
      else $error("exec with error flags");
   a_exec_idx_set: assert property (CMD_EXEC_O |-> RUN_SET[CMD_INDEX_O])
      else $error("unsupported index executed");
   a_idle_gate: assert property (CMD_EXEC_O && IN_IDLE_O |-> CMD_INDEX_O inside {6'h00, 6'h01, 6'h3a})
      else $error("idle card ran a blocked command");
   a_init_ends: assert property (CMD_EXEC_O && CMD_INDEX_O == 6'h01 && IN_IDLE_O |-> ##[1:INIT_LAG] !IN_IDLE_O)
      else $error("idle flag not cleared after init");
   a_len_follows: assert property (CMD_EXEC_O && CMD_INDEX_O == 6'h10 |-> ##[0:1] BLOCK_LEN_O == CMD_ARG_O)
      else $error("block length not taken");
   a_len_holds: assert property ($changed(BLOCK_LEN_O) |-> CMD_EXEC_O || $past(CMD_EXEC_O))
      else $error("block length moved alone");
   a_count_follows: assert property (CMD_EXEC_O && CMD_INDEX_O == 6'h17 |->
      CMD_ARG_O[31:16] == 16'h0000 ##[0:1] BLOCK_COUNT_O == CMD_ARG_O[15:0])
      else $error("block count wrong");
   a_counted_multi: assert property ($rose(COUNTED_O) |-> CMD_INDEX_O == 6'h12)
      else $error("counted flag on other index");
   a_idle_bit_ok: assert property (RESP_STB_O |-> ##[0:1] RESP_O[0] == IN_IDLE_O)
      else $error("idle bit disagrees");
   a_exec_spacing: assert property (CMD_EXEC_O |=> (!CMD_EXEC_O) [*8])
      else $error("executes too close");
   c_write: cover property (CMD_EXEC_O && CMD_INDEX_O == 6'h18);
   c_crc_err: cover property (RESP_STB_O && RESP_O[3]);
   c_counted: cover property ($rose(COUNTED_O));
   c_init_done: cover property ($fell(IN_IDLE_O));
endmodule // scd_cmd_chk
bind scd_cmd_decoder scd_cmd_chk #(.INIT_CYCLES(INIT_CYCLES)) scd_cmd_chk_inst (
   .CLK_I         (CLK_I),
   .SYS_RST_I     (SYS_RST_I),
   .CMD_EXEC_O    (CMD_EXEC_O),
   .CMD_INDEX_O   (CMD_INDEX_O),
   .CMD_ARG_O     (CMD_ARG_O),
   .BLOCK_LEN_O   (BLOCK_LEN_O),
   .BLOCK_COUNT_O (BLOCK_COUNT_O),
   .COUNTED_O     (COUNTED_O),
   .IN_IDLE_O     (IN_IDLE_O),
   .RESP_STB_O    (RESP_STB_O),
   .RESP_O        (RESP_O)
);
`default_nettype wire

// ===== bench/scd_cmd_decoder_tb.sv
// Purpose: Self-checking bench of the card command decoder.
// Assumes: Initialisation count shortened to 8 cycles.
// Notes:   Responses are read back over the serial line.
`timescale 1ns/10ps
`default_nettype none
`include "scd_defines.vh"
module scd_cmd_decoder_tb;
   localparam logic [31:0] RUN_SET = 32'h01872600;
   logic             CLK_I = 1'b0;
   logic             SYS_RST_I = 1'b1;
   logic             WR_BUSY_I = 1'b0;
   wire logic        SCLK_I, CS_N_I, MOSI_I, MISO_O, MISO_OE_N_O, CMD_EXEC_O, COUNTED_O, IN_IDLE_O, RESP_STB_O;
   wire logic [5:0]  CMD_INDEX_O;
   wire logic [31:0] CMD_ARG_O, BLOCK_LEN_O;
   wire logic [15:0] BLOCK_COUNT_O;
   wire logic [7:0]  RESP_O;
   wire logic        miso_w;
   int               failures = 0, num_checks = 0, execs = 0, stbs = 0;
   // A released data line shows the inverse, so a stale bit never passes.
   assign miso_w = MISO_OE_N_O ? ~MISO_O : MISO_O;
   scd_cmd_decoder #(
      .INIT_CYCLES (8)
   ) scd_cmd_decoder_inst (
      .CLK_I         (CLK_I),
      .SYS_RST_I     (SYS_RST_I),
      .SCLK_I        (SCLK_I),
      .CS_N_I        (CS_N_I),
      .MOSI_I        (MOSI_I),
      .WR_BUSY_I     (WR_BUSY_I),
      .MISO_O        (MISO_O),
      .MISO_OE_N_O   (MISO_OE_N_O),
      .CMD_EXEC_O    (CMD_EXEC_O),
      .CMD_INDEX_O   (CMD_INDEX_O),
      .CMD_ARG_O     (CMD_ARG_O),
      .BLOCK_LEN_O   (BLOCK_LEN_O),
      .BLOCK_COUNT_O (BLOCK_COUNT_O),
      .COUNTED_O     (COUNTED_O),
      .IN_IDLE_O     (IN_IDLE_O),
      .RESP_STB_O    (RESP_STB_O),
      .RESP_O        (RESP_O)
   );
   scd_host_model scd_host_model_inst (.sclk_o(SCLK_I), .cs_n_o(CS_N_I), .mosi_o(MOSI_I), .miso_i(miso_w));
   always #10 CLK_I = ~CLK_I;
   // Strobe tallies let each frame be judged by how many pulses it caused.
   // Counted at the falling edge, where the registered pulses have settled.
   always @(negedge CLK_I) begin
      execs += (CMD_EXEC_O === 1'b1);
      stbs += (RESP_STB_O === 1'b1);
   end
   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One frame; a reply of all ones means no response was expected.
   task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] bad,
                      input logic [7:0] er, input logic ex);
      logic [15:0] rsp;
      int          e0;
      int          s0;
      e0 = execs;
      s0 = stbs;
      scd_host_model_inst.frame(idx, arg, bad, rsp);
      chk({16'h0000, rsp}, {16'h0000, 8'hff, er});
      chk(32'(execs - e0), {31'h0, ex});
      chk(32'(stbs - s0), {31'h0, er != 8'hff});
      if (er != 8'hff) begin
         chk({24'h0, RESP_O}, {24'h0, er});
      end
      if (ex) begin
         chk({26'h0, CMD_INDEX_O}, {26'h0, idx});
         chk(CMD_ARG_O, arg);
      end
   endtask
   task automatic t_idle();
      chk(BLOCK_LEN_O, `SCD_BLKLEN_DFLT);
      chk({31'h0, IN_IDLE_O}, 32'h1);
      cmd(6'h10, 32'h00000040, 2'b00, 8'h05, 1'b0);
      chk(BLOCK_LEN_O, `SCD_BLKLEN_DFLT);
      cmd(6'h3a, 32'h0, 2'b00, 8'h01, 1'b1);
   endtask
   task automatic t_init();
      cmd(6'h01, 32'h0, 2'b00, 8'h01, 1'b1);
      chk({31'h0, IN_IDLE_O}, 32'h0);
      cmd(6'h01, 32'h0, 2'b00, 8'h00, 1'b1);
   endtask
   // Every index from 2 to 23, then the unsupported index 39.
   task automatic t_table();
      logic [31:0] arg;
      for (int i = 2; i < 24; i++) begin
         arg = i inside {9, 10, 13} ? 32'h0 : {16'h0000, 10'h294, i[5:0]};
         cmd(i[5:0], arg, 2'b00, RUN_SET[i] ? 8'h00 : 8'h04, RUN_SET[i]);
      end
      cmd(6'h27, 32'h0, 2'b00, 8'h04, 1'b0);
   endtask
   task automatic t_blklen();
      cmd(6'h10, 32'h80000400, 2'b00, 8'h00, 1'b1);
      chk(BLOCK_LEN_O, 32'h80000400);
      cmd(6'h11, 32'h00c0ffee, 2'b00, 8'h00, 1'b1);
      chk(BLOCK_LEN_O, 32'h80000400);
   endtask
   task automatic t_count();
      cmd(6'h17, 32'h00010005, 2'b00, 8'h40, 1'b0);
      cmd(6'h17, 32'h0000ffff, 2'b00, 8'h00, 1'b1);
      chk({16'h0, BLOCK_COUNT_O}, 32'h0000ffff);
      cmd(6'h12, 32'h00001000, 2'b00, 8'h00, 1'b1);
      chk({31'h0, COUNTED_O}, 32'h1);
      cmd(6'h12, 32'h00002000, 2'b00, 8'h00, 1'b1);
      chk({31'h0, COUNTED_O}, 32'h0);
   endtask
   task automatic t_errors();
      cmd(6'h11, 32'h00000010, 2'b01, 8'h08, 1'b0);
      cmd(6'h11, 32'h00000010, 2'b10, 8'hff, 1'b0);
   endtask
   // The first sample of each byte may still show the previous level.
   task automatic t_write();
      logic [7:0] v;
      cmd(6'h18, 32'h00004000, 2'b00, 8'h00, 1'b1);
      @(negedge CLK_I) WR_BUSY_I = 1'b1;
      scd_host_model_inst.byte8(v);
      chk({25'h0, v[6:0]}, 32'h0);
      @(negedge CLK_I) WR_BUSY_I = 1'b0;
      scd_host_model_inst.byte8(v);
      chk({25'h0, v[6:0]}, 32'h7f);
      cmd(6'h0d, 32'h0, 2'b00, 8'h00, 1'b1);
   endtask
   // A mid-run reset brings back idle and the default length, then init again.
   task automatic t_hw_reset();
      @(negedge CLK_I) SYS_RST_I = 1'b1;
      repeat (6) @(negedge CLK_I);
      SYS_RST_I = 1'b0;
      repeat (3) @(negedge CLK_I);
      t_idle();
      t_init();
   endtask
   task automatic t_soft_reset();
      cmd(6'h00, 32'h0, 2'b00, 8'h01, 1'b1);
      t_idle();
   endtask
   // Main sequence after six reset cycles.
   initial begin
      repeat (6) @(negedge CLK_I);
      SYS_RST_I = 1'b0;
      repeat (3) @(negedge CLK_I);
      t_idle();
      t_init();
      t_table();
      t_blklen();
      t_count();
      t_errors();
      t_write();
      t_hw_reset();
      t_soft_reset();
      test_done();
   end
   // A hang is cut short and counted.
   initial begin
      repeat (60000) @(posedge CLK_I);
      failures++;
      test_done();
   end
endmodule // scd_cmd_decoder_tb
`default_nettype wire

// ===== bench/scd_host_model.sv
// Purpose: Host end of the serial link that frames commands.
// Assumes: Tasks are entered on a falling edge of the system clock.
// Notes:   The serial clock stands low between bits, 160 ns a bit.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Host model
// ==========================================================================
module scd_host_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // Idle levels: deselected, data line high.
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
   end
   // One bit: change data while low, sample the reply on the rise.
   task automatic bitx(input logic b, output logic r);
      mosi_o = b;
      #80;
      sclk_o = 1'b1;
      r = miso_i;
      #80;
      sclk_o = 1'b0;
   endtask
   // Eight clocks with the data line high, first sample in bit 7.
   task automatic byte8(output logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, r);
         v = {v[6:0], r};
      end
   endtask
   // Bad bit 0 spoils the check sum, bad bit 1 clears the end bit.
   task automatic frame(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] bad,
                        output logic [15:0] rsp);
      logic [47:0] f;
      logic [6:0]  c;
      logic        r;
      f = {2'b01, idx, arg, 7'h00, ~bad[1]};
      c = 7'h00;
      for (int i = 47; i >= 8; i--) c = {c[5:0], 1'b0} ^ (c[6] ^ f[i] ? 7'h09 : 7'h00);
      f[7:1] = c ^ {6'h00, bad[0]};
      cs_n_o = 1'b0;
      repeat (8) bitx(1'b1, r);
      for (int i = 47; i >= 0; i--) bitx(f[i], r);
      for (int i = 0; i < 16; i++) begin
         bitx(1'b1, r);
         rsp = {rsp[14:0], r};
      end
   endtask
endmodule // scd_host_model
`default_nettype wire

// ===== hw/scd_cmd_decoder.v
// Purpose: Receives, checks and dispatches SPI-mode card command frames.
// Assumes: Serial clock far slower than CLK_I; pins are asynchronous.
// Notes:   Data block transfer is left to an engine driven by CMD_EXEC_O.
`timescale 1ns/10ps
`default_nettype none
`include "scd_defines.vh"

// How it works
// - A frame is six bytes; all 48 bits are gathered before decoding.
// - Frame bits arrive most significant first, bit 47 leading.
// - Start 0, transmission 1, index, argument, CRC7, end bit 1.
// - The CRC7 in bits 7..1 is checked against the first 40 bits.
// - The index field is the plain binary command number.
// - Only indices 0,1,9,10,13,16,17,18,23,24,58 run; others like 2,12 are illegal.
// - Reserved indices 5,6,8,14,19,21,22 are never executed.
// - Index 1 starts initialisation and gets the short response.
// - Index 9 requests the card-specific data register after a short response.
// - Index 10 requests the identity register after a short response.
// - Index 16 stores the 32-bit block length for later block transfers.
// - Index 17 reads one block of current length at the argument address.
// - Index 18 streams blocks until stopped or the preset count is done.
// - Index 23 count sits in bits 15..0, upper bits zero, next command only.
// - Index 24 writes one block, answered by short response then busy.
// - Reset or index 0 enters idle; idle accepts only index 0, init and operating-conditions read.
// - Every well-formed frame gets a response flagging illegal, CRC or operand errors.
// - Busy after the short response holds the data line low until done.
module scd_cmd_decoder #(
   parameter INIT_CYCLES = `SCD_INIT_CYCLES
) (
   input  wire        CLK_I,
   input  wire        SYS_RST_I,
   input  wire        SCLK_I,
   input  wire        CS_N_I,
   input  wire        MOSI_I,
   input  wire        WR_BUSY_I,
   output reg         MISO_O,
   output wire        MISO_OE_N_O,
   output reg         CMD_EXEC_O,
   output reg  [5:0]  CMD_INDEX_O,
   output reg  [31:0] CMD_ARG_O,
   output reg  [31:0] BLOCK_LEN_O,
   output reg  [15:0] BLOCK_COUNT_O,
   output reg         COUNTED_O,
   output reg         IN_IDLE_O,
   output reg         RESP_STB_O,
   output reg  [7:0]  RESP_O
);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   reg  [1:0]  sclk_s_r;
   reg  [1:0]  cs_n_s_r;
   reg  [1:0]  mosi_s_r;
   reg         sclk_d_r;

   // Every pin passes two flops; the second stage feeds logic, and a third flop on the serial clock finds its edges.
   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sclk_s_r <= 2'b00;
         cs_n_s_r <= 2'b11;
         mosi_s_r <= 2'b11;
         sclk_d_r <= 1'b0;
      end else begin
         sclk_s_r <= {sclk_s_r[0], SCLK_I};
         cs_n_s_r <= {cs_n_s_r[0], CS_N_I};
         mosi_s_r <= {mosi_s_r[0], MOSI_I};
         sclk_d_r <= sclk_s_r[1];
      end
   end

   wire sel     = ~cs_n_s_r[1];
   wire mosi    = mosi_s_r[1];
   wire sc_rise = sel & sclk_s_r[1] & ~sclk_d_r;
   wire sc_fall = sel & ~sclk_s_r[1] & sclk_d_r;

   // Driven whenever the card is selected, released otherwise.
   assign MISO_OE_N_O = cs_n_s_r[1];

   // ==========================================================================
   // Frame assembly
   // ==========================================================================
   reg  [47:0] frame_r;
   reg  [5:0]  bit_cnt_r;
   reg         in_frame_r;
   reg         prev_bit_r;
   reg         done_r;
   reg  [4:0]  resp_cnt_r;
   reg         wr_pend_r;
   wire [6:0]  crc;

   // New frames are ignored while a response or a write busy is pending,
   // since write data bytes would otherwise look like command starts.
   wire        rx_ok    = sc_rise & (resp_cnt_r == 5'd0) & ~wr_pend_r;
   wire        starting = rx_ok & ~in_frame_r & ~mosi & prev_bit_r;
   wire        crc_en   = starting | (rx_ok & in_frame_r & (bit_cnt_r < `SCD_CRC_SPAN));

   scd_crc7 scd_crc7_inst (
      .clk_i     (CLK_I),
      .rst_i     (SYS_RST_I),
      .en_i      (crc_en),
      .restart_i (starting),
      .bit_i     (mosi),
      .crc_o     (crc)
   );

   // Bits shift in from the bottom so the first one ends at bit 47.
   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         frame_r    <= 48'h000000000000;
         bit_cnt_r  <= 6'd0;
         in_frame_r <= 1'b0;
         prev_bit_r <= 1'b1;
         done_r     <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (!sel) begin
            in_frame_r <= 1'b0;
            prev_bit_r <= 1'b1;
         end else if (rx_ok) begin
            prev_bit_r <= mosi;
            if (starting) begin
               frame_r    <= {47'h0, mosi};
               bit_cnt_r  <= 6'd1;
               in_frame_r <= 1'b1;
            end else if (in_frame_r) begin
               frame_r   <= {frame_r[46:0], mosi};
               bit_cnt_r <= bit_cnt_r + 6'd1;
               if (bit_cnt_r == `SCD_LAST_BIT) begin
                  in_frame_r <= 1'b0;
                  done_r     <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================================
   // Decode and checks
   // ==========================================================================
   reg         idle_r;
   reg         init_run_r;
   reg  [15:0] init_cnt_r;
   reg         armed_r;
   wire [63:0] supp_mask = `SCD_SUPPORTED_MASK;

   wire [5:0]  idx       = frame_r[`SCD_IDX_HI:`SCD_IDX_LO];
   wire [31:0] arg       = frame_r[`SCD_ARG_HI:`SCD_ARG_LO];
   wire        fmt_ok    = frame_r[`SCD_TX_BIT] & frame_r[`SCD_END_BIT];
   wire        crc_bad   = crc != frame_r[`SCD_CRC_HI:`SCD_CRC_LO];
   // Reserved and unsupported indices both fall outside the mask.
   wire        supported = supp_mask[idx];
   wire        idle_ok   = (idx == `SCD_IDX_RESET) | (idx == `SCD_IDX_INIT) |
                           (idx == `SCD_IDX_RD_OPCOND);
   wire        illegal   = ~supported | (idle_r & ~idle_ok);
   wire        param_bad = (idx == `SCD_IDX_BLKCNT) & (|arg[31:16]);
   wire        respond   = done_r & fmt_ok;
   wire        exec      = respond & ~crc_bad & ~illegal & ~param_bad;
   wire        to_idle   = exec & (idx == `SCD_IDX_RESET);
   wire        init_done = init_run_r & (init_cnt_r == INIT_CYCLES[15:0] - 16'd1);

   reg  [7:0]  short_rsp;

   // The idle flag in the answer shows the state after this command.
   always @* begin
      short_rsp                   = 8'h00;
      short_rsp[`SCD_RSP_IDLE]    = idle_r | to_idle;
      short_rsp[`SCD_RSP_ILLEGAL] = illegal;
      short_rsp[`SCD_RSP_CRC]     = crc_bad;
      short_rsp[`SCD_RSP_PARAM]   = param_bad;
   end

   // ==========================================================================
   // Card state and dispatch
   // ==========================================================================
   // Initialisation is modelled as a fixed count; a real card would end it
   // when its internal setup finishes.
   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         idle_r        <= 1'b1;
         init_run_r    <= 1'b0;
         init_cnt_r    <= 16'h0000;
         armed_r       <= 1'b0;
         BLOCK_LEN_O   <= `SCD_BLKLEN_DFLT;
         BLOCK_COUNT_O <= 16'h0000;
         COUNTED_O     <= 1'b0;
         CMD_EXEC_O    <= 1'b0;
         CMD_INDEX_O   <= 6'h00;
         CMD_ARG_O     <= 32'h00000000;
         IN_IDLE_O     <= 1'b1;
         RESP_STB_O    <= 1'b0;
         RESP_O        <= 8'h00;
      end else begin
         CMD_EXEC_O <= exec;
         RESP_STB_O <= respond;
         IN_IDLE_O  <= idle_r;
         if (respond) begin
            RESP_O <= short_rsp;
         end
         if (init_run_r) begin
            init_cnt_r <= init_cnt_r + 16'd1;
         end
         if (init_done) begin
            idle_r     <= 1'b0;
            init_run_r <= 1'b0;
         end
         if (exec) begin
            CMD_INDEX_O <= idx;
            CMD_ARG_O   <= arg;
            armed_r     <= 1'b0;             // A preset count lasts one command.
            COUNTED_O   <= armed_r & (idx == `SCD_IDX_RD_MULTI);
            case (idx)
               `SCD_IDX_RESET: begin
                  idle_r      <= 1'b1;
                  init_run_r  <= 1'b0;
                  BLOCK_LEN_O <= `SCD_BLKLEN_DFLT;
               end
               `SCD_IDX_INIT: begin
                  if (idle_r && !init_run_r) begin
                     init_run_r <= 1'b1;
                     init_cnt_r <= 16'h0000;
                  end
               end
               `SCD_IDX_BLKLEN: begin
                  BLOCK_LEN_O <= arg;
               end
               `SCD_IDX_BLKCNT: begin
                  BLOCK_COUNT_O <= arg[15:0];
                  armed_r       <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Response shifter and write busy
   // ==========================================================================
   reg  [15:0] resp_sr_r;
   reg         busy_seen_r;

   // One idle byte leads the answer so the host sees a gap before it.
   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         resp_sr_r   <= 16'hffff;
         resp_cnt_r  <= 5'd0;
         wr_pend_r   <= 1'b0;
         busy_seen_r <= 1'b0;
         MISO_O      <= 1'b1;
      end else begin
         if (respond) begin
            resp_sr_r  <= {`SCD_RESP_LEAD, short_rsp};
            resp_cnt_r <= `SCD_RESP_BITS;
            wr_pend_r  <= exec & (idx == `SCD_IDX_WR_SINGLE);
         end else if (!sel) begin
            resp_cnt_r <= 5'd0;     // Deselect drops the answer but not the busy.
            MISO_O     <= 1'b1;
         end else if (sc_fall && resp_cnt_r != 5'd0) begin
            MISO_O     <= resp_sr_r[15];
            resp_sr_r  <= {resp_sr_r[14:0], 1'b1};
            resp_cnt_r <= resp_cnt_r - 5'd1;
         end else if (resp_cnt_r == 5'd0 && wr_pend_r && sc_fall) begin
            MISO_O <= ~WR_BUSY_I;
         end else if (resp_cnt_r == 5'd0 && !wr_pend_r && sc_fall) begin
            MISO_O <= 1'b1;
         end
         if (wr_pend_r && WR_BUSY_I) begin
            busy_seen_r <= 1'b1;
         end
         if (wr_pend_r && busy_seen_r && !WR_BUSY_I) begin
            wr_pend_r   <= 1'b0;
            busy_seen_r <= 1'b0;
         end
      end
   end

endmodule // scd_cmd_decoder
`default_nettype wire

// ===== hw/scd_crc7.v
// Purpose: Serial seven-bit CRC over the head of a command frame.
// Assumes: One bit per enable pulse, most significant bit first.
// Notes:   A restart pulse seeds the sum with zero on the same bit.
`timescale 1ns/10ps
`default_nettype none
`include "scd_defines.vh"

module scd_crc7 (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       en_i,
   input  wire       restart_i,
   input  wire       bit_i,
   output reg  [6:0] crc_o
);

   wire [6:0] base = restart_i ? 7'h00 : crc_o;
   wire       fb   = base[6] ^ bit_i;

   // ==========================================================================
   // Shift register
   // ==========================================================================
   // Feedback taps follow the polynomial x^7 + x^3 + 1.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         crc_o <= 7'h00;
      end else if (en_i) begin
         crc_o <= {base[5:0], 1'b0} ^ ({7{fb}} & `SCD_CRC7_POLY);
      end
   end

endmodule // scd_crc7
`default_nettype wire

// ===== hw/scd_defines.vh
// Purpose: Shared constants of the card command decoder.
// Assumes: Included by the decoder and its CRC unit.
// Notes:   Frame field positions, response bits and defaults.
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH

// ==========================================================================
// Frame layout
// ==========================================================================
`define SCD_FRAME_BITS     6'd48
`define SCD_LAST_BIT       6'd47
`define SCD_CRC_SPAN       6'd40
`define SCD_TX_BIT         46
`define SCD_IDX_HI         45
`define SCD_IDX_LO         40
`define SCD_ARG_HI         39
`define SCD_ARG_LO         8
`define SCD_CRC_HI         7
`define SCD_CRC_LO         1
`define SCD_END_BIT        0
`define SCD_CRC7_POLY      7'h09

// ==========================================================================
// Command indices and the supported set
// ==========================================================================
`define SCD_IDX_RESET      6'h00
`define SCD_IDX_INIT       6'h01
`define SCD_IDX_BLKLEN     6'h10
`define SCD_IDX_RD_MULTI   6'h12
`define SCD_IDX_BLKCNT     6'h17
`define SCD_IDX_WR_SINGLE  6'h18
`define SCD_IDX_RD_OPCOND  6'h3a
`define SCD_SUPPORTED_MASK 64'h0400000001872603

// ==========================================================================
// Short response bits and defaults
// ==========================================================================
`define SCD_RSP_IDLE       0
`define SCD_RSP_ILLEGAL    2
`define SCD_RSP_CRC        3
`define SCD_RSP_PARAM      6
`define SCD_RESP_LEAD      8'hff
`define SCD_RESP_BITS      5'd16
`define SCD_BLKLEN_DFLT    32'h00000200
`define SCD_INIT_CYCLES    1000

`endif
